// *** hw/bsc_pkg.sv ***
package bsc_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 8;      // register port address width
   localparam int unsigned DATA_W = 32;     // register port data width
   localparam int unsigned STRAP_W = 24;    // number of strap address lines

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CONFIG  = 8'h00;  // boot strap configuration
   localparam logic [7:0] OFS_TIMING  = 8'h04;  // expansion-bus timing control
   localparam logic [7:0] OFS_SPEED   = 8'h08;  // fused grade and effective clock set
   localparam logic [7:0] OFS_DECODE  = 8'h0c;  // decode probe: address in, target out

   // field positions of the configuration register
   localparam int unsigned BIT_MAP_SEL   = 31;  // expansion bus placement
   localparam int unsigned BIT_CLK_HI    = 23;  // core clock-set msb
   localparam int unsigned BIT_CLK_LO    = 21;  // core clock-set lsb
   localparam int unsigned BIT_USER_HI   = 20;  // user field msb
   localparam int unsigned BIT_USER_LO   = 17;  // user field lsb
   localparam int unsigned BIT_PCI_66    = 4;   // pci clock speed
   localparam int unsigned BIT_RSVD_ONE  = 3;   // reserved, written as one
   localparam int unsigned BIT_ARB_EN    = 2;   // bus_arbiter_enable
   localparam int unsigned BIT_PCI_HOST  = 1;   // pci host role
   localparam int unsigned BIT_FLASH_8   = 0;   // boot flash width

   // bits of the configuration register that hold state
   localparam logic [31:0] CFG_LIVE_MASK = 32'h80FE_001F;
   // bits that software may rewrite (map select, user field, low controls)
   localparam logic [31:0] CFG_WR_MASK   = 32'h801E_0017;
   // value held while reset is asserted: map bit set, straps pulled up
   localparam logic [31:0] CFG_RESET     = 32'h80FE_001F;

   // memory map figures
   localparam logic [31:0] BOOT_BASE   = 32'h0000_0000;  // boot-mode bus base
   localparam logic [31:0] NORM_BASE   = 32'h5000_0000;  // normal-mode bus base
   localparam logic [31:0] WIN_MASK    = 32'hF000_0000;  // 256 MB window compare
   localparam logic [31:0] ROM_MASK    = 32'hFF00_0000;  // 16 MB boot rom window
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000; // first fetch address

   // timing register defaults
   localparam logic [3:0] TIMING_W     = 4'h4;          // timing field width
   localparam logic [3:0] EXTRA_WAIT_DFLT = 4'h0;       // extra sample cycles
   localparam logic [2:0] FUSE_DFLT    = 3'h0;          // neutral fused grade

   // decode targets
   typedef enum logic [1:0] {
      BSC_TGT_NONE,
      BSC_TGT_EXP,
      BSC_TGT_SDRAM,
      BSC_TGT_ROM
   } bsc_target_type;

   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bsc_req_type;

   // decoded configuration seen by the chip
   typedef struct packed {
      logic       map_boot;
      logic [2:0] core_clock_set;
      logic [3:0] user_field;
      logic       pci_66;
      logic       bus_arbiter_enable;
      logic       pci_host;
      logic       flash_8bit;
   } bsc_cfg_type;

endpackage

// *** hw/bsc_clock_limit.sv ***
`timescale 1ns/1ps
// picks the slower of strapped and fused clock settings; a larger code
// means a slower core, so the strap can never raise the speed
module bsc_clock_limit
(
   input  wire logic [2:0] fused,
   input  wire logic [2:0] strapped,
   output logic      [2:0] effective
);

   // never below the fused setting
   always_comb
   begin
      if (strapped > fused)
      begin
         effective = strapped;  // slower by strap
      end
      else
      begin
         effective = fused;     // strap would over-clock, keep fuse
      end
   end

endmodule

// *** hw/bsc_boot_strap_config.sv ***
`timescale 1ns/1ps
module bsc_boot_strap_config
(
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   input  wire logic [23:0]          strap_address_lines_in,
   output logic      [23:0]          strap_address_lines_out,
   output logic      [23:0]          strap_address_lines_oe_n,
   input  wire logic [23:0]          exp_addr_drive,
   input  wire logic [2:0]           fused_grade,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   output logic                      map_boot,
   output logic      [2:0]           core_clock_set,
   output logic      [3:0]           user_field,
   output logic                      pci_66,
   output logic                      bus_arbiter_enable,
   output logic                      pci_host,
   output logic                      flash_8bit,
   output logic      [3:0]           extra_wait,
   output logic      [31:0]          fetch_start
);

   // bundled register request
   bsc_pkg::bsc_req_type req;
   // configuration register storage
   logic [31:0]          cfg;
   // one-shot marker: straps not yet captured since reset
   logic                 capture_pending;
   // timing register
   logic [3:0]           wait_cycles;
   // decode probe address and its result
   logic [31:0]          probe_addr;
   bsc_pkg::bsc_target_type probe_tgt;
   // decoded view of the configuration
   bsc_pkg::bsc_cfg_type cfg_view;
   // clock set after fuse limit
   logic [2:0]           clk_eff;
   // next read data
   logic [31:0]          next_rdata;
   // strap word with reserved line forced high
   logic [31:0]          strap_word;

   // register map seen by software:
   //   0x00 configuration word, straps captured at reset release
   //   0x04 expansion-bus timing, extra read sample cycles in [3:0]
   //   0x08 speed view, effective clock set in [6:4], fused grade in [2:0]
   //   0x0c decode probe, write an address, read its target in [1:0]
   // every other offset reads zero and drops writes
   // read data stands for one cycle only, then returns to zero, so a
   // stale answer can never be taken for a fresh one
   // the clock-set field is read-only: software may look at it but only
   // the straps and the fuse decide it, so no write can over-clock the core
   // the map bit is the one field boot code is expected to rewrite; the
   // other writable fields are there for bring-up and test

   // gather the port into one request
   assign req.addr  = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.wr    = reg_wr;
   assign req.rd    = reg_rd;

   // strap word: map bit set, straps in 23..0, unused bits dropped
   // the map bit has no strap line of its own, so it is forced here
   // line 3 is reserved and always taken as one, whatever the board does
   // the other reserved lines are masked off so they can never read back as set
   always_comb
   begin
      strap_word = {8'h80, strap_address_lines_in} & bsc_pkg::CFG_LIVE_MASK;
      strap_word[bsc_pkg::BIT_MAP_SEL] = 1'b1;
      strap_word[bsc_pkg::BIT_RSVD_ONE] = 1'b1;
   end

   // limit strapped clock-set against the fuse
   // the strap may only slow the core, so a board strapped for a faster
   // grade still runs at the fused speed
   bsc_clock_limit bsc_clock_limit_i
   (
      .fused    (fused_grade),
      .strapped (cfg[bsc_pkg::BIT_CLK_HI:bsc_pkg::BIT_CLK_LO]),
      .effective(clk_eff)
   );

   // capture marker: armed by reset, cleared at first edge after release
   // a config write that lands on the capture edge is lost: the strap load takes
   // priority, so software must leave the first edge after release alone
   // the marker also holds the pins released for exactly that one edge
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         capture_pending <= 1'b1;
      end
      else
      begin
         capture_pending <= 1'b0;
      end
   end

   // address pins: inputs during reset and capture, then driven outward
   // the pins stay released for the capture edge itself; driving them one
   // edge early would override the board's pull resistors before sampling
   // after capture the bus owns them until the next reset
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strap_address_lines_oe_n <= 24'hFF_FFFF;  // released, board pulls decide
         strap_address_lines_out  <= 24'h00_0000;
      end
      else if (capture_pending)
      begin
         strap_address_lines_oe_n <= 24'hFF_FFFF;  // still sampling
         strap_address_lines_out  <= 24'h00_0000;
      end
      else
      begin
         strap_address_lines_oe_n <= 24'h00_0000;  // bus owns the pins
         strap_address_lines_out  <= exp_addr_drive;
      end
   end

   // configuration register: strap capture, then software rewrites
   // reserved bits never load from software, so they keep the zero that
   // the capture mask left there; bit 3 keeps its forced one the same way
   // the clock-set field is outside the write mask on purpose
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg <= bsc_pkg::CFG_RESET;  // map bit one at reset
      end
      else if (capture_pending)
      begin
         // pins sampled on the first edge after release
         cfg <= strap_word;
      end
      else if (req.wr && req.addr == bsc_pkg::OFS_CONFIG)
      begin
         // writable fields only; reserved bits keep zero, bit 3 keeps one
         // the clock-set field is fixed by straps, never by software
         // boot software clears map bit here
         cfg <= (cfg & ~bsc_pkg::CFG_WR_MASK) | (req.wdata & bsc_pkg::CFG_WR_MASK);
      end
   end

   // timing register: extra sample cycles for slow edges
   // a heavily loaded line that rises slowly needs one more cycle before
   // its level is trusted; software sets the count and the bus controller
   // reads it from extra_wait
   // only the low nibble is kept, upper write bits are dropped
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wait_cycles <= bsc_pkg::EXTRA_WAIT_DFLT;
      end
      else if (req.wr && req.addr == bsc_pkg::OFS_TIMING)
      begin
         wait_cycles <= req.wdata[3:0];
      end
   end

   // decode probe address register
   // software writes any address here and reads back where it would land
   // under the current map, which makes the map switch visible
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         probe_addr <= 32'h0000_0000;
      end
      else if (req.wr && req.addr == bsc_pkg::OFS_DECODE)
      begin
         probe_addr <= req.wdata;
      end
   end

   // decoded configuration view
   // one slice per field, the clock set from the fuse limit, so each output has a single source
   always_comb
   begin
      cfg_view.map_boot           = cfg[bsc_pkg::BIT_MAP_SEL];
      cfg_view.core_clock_set     = clk_eff;
      cfg_view.user_field         = cfg[bsc_pkg::BIT_USER_HI:bsc_pkg::BIT_USER_LO];
      cfg_view.pci_66             = cfg[bsc_pkg::BIT_PCI_66];
      cfg_view.bus_arbiter_enable = cfg[bsc_pkg::BIT_ARB_EN];
      cfg_view.pci_host           = cfg[bsc_pkg::BIT_PCI_HOST];
      cfg_view.flash_8bit         = cfg[bsc_pkg::BIT_FLASH_8];
   end

   // memory map decode of the probe address
   // the map bit is read live, so a probe read right after a map write
   // already sees the new placement
   // addresses outside every window decode to nothing
   // the rom always sits at the low 16 MB of the expansion window, so it
   // moves together with the bus when the map bit clears
   always_comb
   begin
      probe_tgt = bsc_pkg::BSC_TGT_NONE;
      if (cfg_view.map_boot)
      begin
         // boot mode: expansion bus in the bottom 256 MB
         if ((probe_addr & bsc_pkg::WIN_MASK) == bsc_pkg::BOOT_BASE)
         begin
            // rom region at the bottom 16 MB
            if ((probe_addr & bsc_pkg::ROM_MASK) == bsc_pkg::BOOT_BASE)
            begin
               probe_tgt = bsc_pkg::BSC_TGT_ROM;
            end
            else
            begin
               probe_tgt = bsc_pkg::BSC_TGT_EXP;
            end
         end
      end
      else
      begin
         // normal mode: sdram low, bus moved up
         if ((probe_addr & bsc_pkg::WIN_MASK) == bsc_pkg::BOOT_BASE)
         begin
            probe_tgt = bsc_pkg::BSC_TGT_SDRAM;
         end
         else if ((probe_addr & bsc_pkg::WIN_MASK) == bsc_pkg::NORM_BASE)
         begin
            if ((probe_addr & ~bsc_pkg::WIN_MASK & bsc_pkg::ROM_MASK) == 32'h0000_0000)
            begin
               probe_tgt = bsc_pkg::BSC_TGT_ROM;
            end
            else
            begin
               probe_tgt = bsc_pkg::BSC_TGT_EXP;
            end
         end
      end
   end

   // read mux, unmapped offsets read zero
   // the address is decoded in full, so aliases of the four offsets
   // read zero as well
   // the speed view keeps bit 3 at zero as a gap between its two fields
   always_comb
   begin
      case (req.addr)
         bsc_pkg::OFS_CONFIG:
         begin
            next_rdata = cfg & bsc_pkg::CFG_LIVE_MASK;
         end
         bsc_pkg::OFS_TIMING:
         begin
            next_rdata = {28'h000_0000, wait_cycles};
         end
         bsc_pkg::OFS_SPEED:
         begin
            next_rdata = {25'h000_0000, clk_eff, 1'b0, fused_grade};
         end
         bsc_pkg::OFS_DECODE:
         begin
            next_rdata = {30'h0000_0000, probe_tgt};
         end
         default:
         begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data register, valid the cycle after the strobe
   // returning to zero between answers keeps idle read data free of
   // configuration bits
   // reads never change state, so they may follow writes with no gap
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= 32'h0000_0000;
      end
      else if (req.rd)
      begin
         reg_rdata <= next_rdata;
      end
      else
      begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // registered configuration outputs
   // every output comes from a flip-flop, one edge behind the register
   // reset values put the chip in boot placement with the FUSE_DFLT clock set
   // until the straps have been captured
   // the first fetch address never moves; the map bit decides which
   // device answers it
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         map_boot           <= 1'b1;
         core_clock_set     <= bsc_pkg::FUSE_DFLT;
         user_field         <= 4'h0;
         pci_66             <= 1'b0;
         bus_arbiter_enable <= 1'b0;
         pci_host           <= 1'b0;
         flash_8bit         <= 1'b0;
         extra_wait         <= bsc_pkg::EXTRA_WAIT_DFLT;
         fetch_start        <= bsc_pkg::RESET_VECTOR;
      end
      else
      begin
         map_boot           <= cfg_view.map_boot;
         core_clock_set     <= cfg_view.core_clock_set;
         user_field         <= cfg_view.user_field;
         pci_66             <= cfg_view.pci_66;
         bus_arbiter_enable <= cfg_view.bus_arbiter_enable;
         pci_host           <= cfg_view.pci_host;
         flash_8bit         <= cfg_view.flash_8bit;
         extra_wait         <= wait_cycles;
         fetch_start        <= bsc_pkg::RESET_VECTOR;
      end
   end

endmodule

// *** verification/bsc_strap_board.sv ***
`timescale 1ns/1ps
// board side of the strap pins: weak pull-ups, fitted pull-downs
module bsc_strap_board
(
   input  wire logic [23:0] pull_down,
   input  wire logic [23:0] pin_out,
   input  wire logic [23:0] pin_oe_n,
   output logic      [23:0] pin_level
);
   // driven pin wins, else a fitted pull-down, else the pull-up
   always_comb
   begin
      for (int b = 0; b < 24; b++)
      begin
         // line 3 never carries a pull-down on this board
         pin_level[b] = !pin_oe_n[b] ? pin_out[b] : !(pull_down[b] && b != 3);
      end
   end
endmodule

// *** verification/bsc_boot_strap_config_props.sv ***
`timescale 1ns/1ps
// port-level checks of the strap configuration block
module bsc_boot_strap_config_props
(
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic [23:0] strap_address_lines_in,
   input wire logic [23:0] strap_address_lines_oe_n,
   input wire logic [2:0]  fused_grade,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        map_boot,
   input wire logic [2:0]  core_clock_set,
   input wire logic [3:0]  user_field,
   input wire logic [31:0] fetch_start
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // write strobe aimed at the configuration word
   wire cfg_wr = reg_wr && reg_addr == 8'h00;

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   a_clock_not_raised: assert property ($past(arst_n, 2) |->
      core_clock_set >= fused_grade)
      else $error("core clock set faster than fused grade");
   a_oe_release: assert property (!$past(arst_n) |->
      ##1 strap_address_lines_oe_n == 24'hFF_FFFF ##1 strap_address_lines_oe_n == 24'h00_0000)
      else $error("strap pins not released as inputs for capture");
   a_strap_user: assert property (!$past(arst_n) |-> ##2 user_field ==
      $past(strap_address_lines_in[20:17], 2))
      else $error("user field not captured at first edge");
   a_strap_clock: assert property (!$past(arst_n) |-> ##2 core_clock_set ==
      ($past(strap_address_lines_in[23:21], 2) > fused_grade ?
       $past(strap_address_lines_in[23:21], 2) : fused_grade))
      else $error("clock set not the slower of strap and fuse");
   a_map_reset: assert property (!$past(arst_n) |-> map_boot ##1 map_boot ##1 map_boot)
      else $error("map bit not boot after reset");
   a_map_write: assert property (cfg_wr ##1 !cfg_wr |-> ##1 map_boot ==
      $past(reg_wdata[31], 2))
      else $error("map bit does not follow write");
   a_clock_set_kept: assert property (cfg_wr |-> ##2 core_clock_set ==
      $past(core_clock_set, 2))
      else $error("write changed the clock set");
   a_rsvd_read: assert property (reg_rd && reg_addr == 8'h00 |=>
      reg_rdata[30:24] == 7'h00 && reg_rdata[16:5] == 12'h000 && reg_rdata[3])
      else $error("reserved configuration bits read wrong");
   a_unmapped_zero: assert property (reg_rd && reg_addr[7:4] != 4'h0 |=>
      reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_fetch_zero: assert property (fetch_start == 32'h0000_0000)
      else $error("fetch start not at address zero");

   c_map_clear: cover property (cfg_wr && !reg_wdata[31]);
   c_capture: cover property (!$past(arst_n));
   c_probe_read: cover property (reg_rd && reg_addr == 8'h0c);
endmodule

bind bsc_boot_strap_config bsc_boot_strap_config_props bsc_boot_strap_config_props_i
(
   .clk_sys(clk_sys), .arst_n(arst_n), .strap_address_lines_in(strap_address_lines_in),
   .strap_address_lines_oe_n(strap_address_lines_oe_n), .fused_grade(fused_grade),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .map_boot(map_boot), .core_clock_set(core_clock_set),
   .user_field(user_field), .fetch_start(fetch_start)
);

// *** verification/boot_strap_config_test.sv ***
`timescale 1ns/1ps
// strap capture, register traffic and decode probe of the config block
module boot_strap_config_test;
   logic        clk_sys;
   logic        arst_n;
   logic [23:0] pull_down;        // fitted pull-downs
   logic [23:0] exp_addr_drive;   // address the bus wants out
   logic [2:0]  fused_grade;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [23:0] strap_in;
   logic [23:0] strap_out;
   logic [23:0] strap_oe_n;
   logic        map_boot;
   logic [2:0]  core_clock_set;
   logic [3:0]  user_field;
   logic [3:0]  bits_low;         // pci speed, arbiter, host, flash width
   logic [3:0]  extra_wait;
   logic [31:0] fetch_start;
   logic [31:0] seed;             // xorshift state
   logic [31:0] notes[$];         // expected read answers, oldest first
   logic        rd_seen;          // read strobe seen at last edge
   logic [31:0] cfg_exp;          // model of the configuration word
   int          miscompares;
   int          checks_done;
   // probe addresses and targets: boot map first, normal map after
   localparam logic [31:0] PROBE_A [8] = '{32'h0000_0000, 32'h00FF_FFFF, 32'h0100_0000,
      32'h0FFF_FFFF, 32'h0000_0000, 32'h0FFF_FFFF, 32'h5000_0000, 32'h5FFF_FFFF};
   localparam logic [1:0]  PROBE_T [8] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1};

   bsc_strap_board bsc_strap_board_i (.pull_down(pull_down), .pin_out(strap_out),
      .pin_oe_n(strap_oe_n), .pin_level(strap_in));
   bsc_boot_strap_config bsc_boot_strap_config_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .strap_address_lines_in(strap_in), .strap_address_lines_out(strap_out),
      .strap_address_lines_oe_n(strap_oe_n), .exp_addr_drive(exp_addr_drive),
      .fused_grade(fused_grade), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .map_boot(map_boot),
      .core_clock_set(core_clock_set), .user_field(user_field), .pci_66(bits_low[3]),
      .bus_arbiter_enable(bits_low[2]), .pci_host(bits_low[1]), .flash_8bit(bits_low[0]),
      .extra_wait(extra_wait), .fetch_start(fetch_start));

   // free-running system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         miscompares++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // bus cycles: each holds its strobe for one edge, so calls may follow
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      notes.push_back(want);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
   endtask

   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask

   // config write, tracked in the model through the writable bits
   task automatic wr_cfg(input logic [31:0] d);
      cfg_exp = (cfg_exp & ~32'h801E_0017) | (d & 32'h801E_0017);
      wr(8'h00, d | 32'h0000_0008);
   endtask

   // read answers stand one cycle after the strobe
   always @(posedge clk_sys)
   begin
      if (rd_seen)
         check(reg_rdata, notes.pop_front());
      rd_seen <= reg_rd;
   end

   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end

   initial
   begin
      logic [2:0] eff;
      logic [3:0] tw;   // timing value written this pass
      arst_n = 1'b0;
      {pull_down, exp_addr_drive, fused_grade, reg_addr, reg_wdata} = '0;
      {reg_wr, reg_rd} = '0;
      seed = 32'h0000_0D9E;
      miscompares = 0;
      checks_done = 0;
      for (int n = 0; n < 3; n++)
      begin
         // reset with a new strap fit; first pass leaves all lines undriven
         arst_n <= 1'b0;
         pull_down <= (n == 0) ? 24'h00_0000 : 24'(next_rand());
         fused_grade <= 3'(next_rand());
         exp_addr_drive <= 24'(next_rand());
         repeat (10) @(posedge clk_sys);
         arst_n <= 1'b1;
         repeat (3) @(posedge clk_sys);
         cfg_exp = 32'h8000_0008 | ({8'h00, ~pull_down} & 32'h00FE_0017);
         eff = cfg_exp[23:21] > fused_grade ? cfg_exp[23:21] : fused_grade;
         rd(8'h00, cfg_exp);
         rd(8'h08, {25'h0, eff, 1'b0, fused_grade});
         idle();
         @(negedge clk_sys);
         check(map_boot, 1'b1);
         check(core_clock_set, eff);
         check(user_field, cfg_exp[20:17]);
         check(bits_low, {cfg_exp[4], cfg_exp[2:0]});
         check(fetch_start, 32'h0000_0000);
         check(strap_out, exp_addr_drive);
         check(strap_oe_n, 24'h00_0000);
         @(posedge clk_sys);
         // decode probe in both maps; boot software clears the map bit midway
         for (int i = 0; i < 8; i++)
         begin
            if (i == 4)
               wr_cfg(cfg_exp & 32'h7FFF_FFFF);
            wr(8'h0c, PROBE_A[i]);
            rd(8'h0c, {30'h0, PROBE_T[i]});
         end
         // random config writes read back at once
         for (int i = 0; i < 4; i++)
         begin
            wr_cfg(next_rand());
            rd(8'h00, cfg_exp);
         end
         idle();
         @(negedge clk_sys);
         check(map_boot, cfg_exp[31]);
         check(user_field, cfg_exp[20:17]);
         check(bits_low, {cfg_exp[4], cfg_exp[2:0]});
         @(posedge clk_sys);
         // timing register and an unmapped place
         tw = 4'(next_rand());
         wr(8'h04, {28'h0, tw});
         rd(8'h04, {28'h0, tw});
         wr(8'h40, next_rand());
         rd(8'h40, 32'h0000_0000);
         idle();
         @(negedge clk_sys);
         check(extra_wait, tw);
         @(posedge clk_sys);
         $display("pass %0d done", n);
      end
      end_sim();
   end
endmodule
